//--- src/eic_pkg.sv
// What this block does
// [R1] Clear-error opcode clears flags by type field
// [R2] Type 0 all, 1..5 one flag each
// [R3] Enable opcode enables irq; 255 enables globally
// [R4] Disable opcode disables irq; 255 disables globally
// [R5] Vector opcode stores value as handler entry
// [R6] Later vector command replaces stored entry
// [R7] Issuer uses vector command only in programs
// [R8] Return opcode restores saved context, resumes flow
// [R9] Handlers end with return; no fall-through
// [R10] Return ends active handler
// [R11] Taken irq saves context, jumps to vector
// [R12] Direct mode replies status 100 for all five
package eic_pkg;

  // Opcodes handled here
  localparam logic [7:0] OP_ENABLE = 8'h19;
  localparam logic [7:0] OP_DISABLE = 8'h1A;
  localparam logic [7:0] OP_CLEAR_ERR = 8'h24;
  localparam logic [7:0] OP_VECTOR = 8'h25;
  localparam logic [7:0] OP_RETURN = 8'h26;
  localparam logic [7:0] TYPE_GLOBAL = 8'hFF;
  localparam logic [7:0] STATUS_OK = 8'h64;

  // Clear-error type codes
  localparam logic [7:0] CLR_ALL = 8'h00;
  localparam logic [7:0] CLR_LAST = 8'h05;

  // Error flag bit positions
  localparam int NUM_ERR = 5;
  localparam int ERR_TIMEOUT = 0;
  localparam int ERR_ALARM = 1;
  localparam int ERR_DEVIATION = 2;
  localparam int ERR_POSITION = 3;
  localparam int ERR_SHUTDOWN = 4;

  // Event status bits
  localparam int NUM_EVT = 3;
  localparam int EVT_ENTER = 0;
  localparam int EVT_RETURN = 1;
  localparam int EVT_ERROR = 2;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] ADDR_ERR = 8'h00;
  localparam logic [7:0] ADDR_ENABLE = 8'h04;
  localparam logic [7:0] ADDR_EVENT = 8'h08;
  localparam logic [7:0] ADDR_MASK = 8'h0C;
  localparam logic [7:0] ADDR_STATE = 8'h10;
  localparam logic [7:0] ADDR_VEC_BASE = 8'h40;
  localparam int STATE_HANDLER = 0;
  localparam int STATE_GLOBAL = 1;
  localparam int STATE_ACTIVE_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // Command from the frame decoder or program fetch
  typedef struct packed {
    logic direct;
    logic [7:0] opcode;
    logic [7:0] itype;
    logic [7:0] bank;
    logic [31:0] value;
  } eic_cmd_t;

  // Direct-mode reply
  typedef struct packed {
    logic [7:0] status;
    logic [7:0] opcode;
    logic [31:0] value;
  } eic_reply_t;

  // Interpreter context saved across a handler
  typedef struct packed {
    logic [31:0] accu;
    logic [31:0] xreg;
    logic [7:0] flags;
    logic [31:0] pc;
  } eic_ctx_t;

endpackage

//--- src/eic_axil_slave.sv
module eic_axil_slave import eic_pkg::*; (
  input wire logic clk_i, // System clock
  input wire logic reset_i, // Sync reset, high
  input wire logic [ADDR_W-1:0] s_awaddr, // Write address
  input wire logic s_awvalid, // Write address valid
  output logic s_awready, // Write address ready
  input wire logic [31:0] s_wdata, // Write data
  input wire logic [3:0] s_wstrb, // Byte enables
  input wire logic s_wvalid, // Write data valid
  output logic s_wready, // Write data ready
  output logic [1:0] s_bresp, // Write response
  output logic s_bvalid, // Write response valid
  input wire logic s_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_araddr, // Read address
  input wire logic s_arvalid, // Read address valid
  output logic s_arready, // Read address ready
  output logic [31:0] s_rdata, // Read data
  output logic [1:0] s_rresp, // Read response
  output logic s_rvalid, // Read data valid
  input wire logic s_rready, // Read data ready
  input wire logic [31:0] rd_word_i, // Word at s_araddr
  input wire logic rd_hit_i, // s_araddr is mapped
  input wire logic wr_hit_i, // wr_addr_o is mapped
  output logic wr_en_o, // One-cycle write strobe
  output logic [ADDR_W-1:0] wr_addr_o, // Write address
  output logic [31:0] wr_data_o // Write data, strobes applied
);

  logic have_aw;
  logic have_w;
  wire aw_take = s_awvalid & s_awready;
  wire w_take = s_wvalid & s_wready;
  wire wr_go = have_aw & have_w & ~s_bvalid;
  wire ar_take = s_arvalid & s_arready;

  // Address and data may come in either order
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      have_aw <= 1'b0;
      have_w <= 1'b0;
      s_awready <= 1'b0;
      s_wready <= 1'b0;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
      wr_en_o <= 1'b0;
      wr_addr_o <= '0;
      wr_data_o <= '0;
    end else begin
      if (aw_take) begin
        have_aw <= 1'b1;
        wr_addr_o <= s_awaddr;
      end
      if (w_take) begin
        have_w <= 1'b1;
        for (int b = 0; b < 4; b++) begin
          wr_data_o[8*b +: 8] <= s_wstrb[b] ? s_wdata[8*b +: 8] : 8'h00;
        end
      end
      s_awready <= ~have_aw & ~aw_take;
      s_wready <= ~have_w & ~w_take;
      wr_en_o <= wr_go;
      if (wr_go) begin
        have_aw <= 1'b0;
        have_w <= 1'b0;
        s_bvalid <= 1'b1;
        s_bresp <= wr_hit_i ? RESP_OKAY : RESP_DECERR;
      end else if (s_bvalid & s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read answers one cycle after the address is taken
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      s_arready <= 1'b0;
      s_rvalid <= 1'b0;
      s_rdata <= '0;
      s_rresp <= RESP_OKAY;
    end else begin
      s_arready <= ~s_rvalid & ~ar_take & ~s_arready;
      if (ar_take) begin
        s_rvalid <= 1'b1;
        s_rdata <= rd_hit_i ? rd_word_i : 32'h0000_0000;
        s_rresp <= rd_hit_i ? RESP_OKAY : RESP_DECERR;
      end else if (s_rvalid & s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

endmodule

//--- src/eic_core.sv
// Implementation choices: the AXI4-Lite interface to the registers and the register addresses.
module eic_core import eic_pkg::*; #(
  parameter int NUM_IRQ = 16
) (
  input wire logic clk_i, // System clock, 10 MHz
  input wire logic reset_i, // Sync reset, high
  input wire logic cmd_valid_i, // Command offered
  input wire eic_cmd_t cmd_i, // Command fields
  output logic cmd_ready_o, // Command accepted
  output logic rsp_valid_o, // Direct-mode reply pulse
  output eic_reply_t rsp_o, // Reply fields
  input wire logic [NUM_IRQ-1:0] irq_req_i, // Interrupt source pulses
  input wire logic boundary_i, // Interpreter between instructions
  input wire eic_ctx_t ctx_i, // Live interpreter context
  output logic jump_valid_o, // Enter handler pulse
  output logic [31:0] jump_pc_o, // Handler entry address
  output logic restore_valid_o, // Handler return pulse
  output eic_ctx_t restore_o, // Context to reload
  input wire logic [NUM_ERR-1:0] err_set_i, // Error flag set pulses
  output logic [NUM_ERR-1:0] err_flags_o, // Error flags
  input wire logic [ADDR_W-1:0] s_awaddr, // AXI write address
  input wire logic s_awvalid, // AXI write address valid
  output logic s_awready, // AXI write address ready
  input wire logic [31:0] s_wdata, // AXI write data
  input wire logic [3:0] s_wstrb, // AXI byte enables
  input wire logic s_wvalid, // AXI write data valid
  output logic s_wready, // AXI write data ready
  output logic [1:0] s_bresp, // AXI write response
  output logic s_bvalid, // AXI write response valid
  input wire logic s_bready, // AXI write response ready
  input wire logic [ADDR_W-1:0] s_araddr, // AXI read address
  input wire logic s_arvalid, // AXI read address valid
  output logic s_arready, // AXI read address ready
  output logic [31:0] s_rdata, // AXI read data
  output logic [1:0] s_rresp, // AXI read response
  output logic s_rvalid, // AXI read data valid
  input wire logic s_rready, // AXI read data ready
  output logic irq_o // Unmasked event pending
);

  localparam int IDX_W = (NUM_IRQ > 1) ? $clog2(NUM_IRQ) : 1;
  localparam logic [7:0] IRQ_COUNT = 8'(NUM_IRQ);

  // Handler state
  typedef enum logic {
    EIC_NORMAL,
    EIC_HANDLER
  } eic_mode_t;

  eic_mode_t mode;
  eic_mode_t next_mode;
  logic global_en;
  logic [NUM_IRQ-1:0] irq_enable;
  logic [NUM_IRQ-1:0] irq_pending;
  logic [31:0] vec_table [NUM_IRQ];
  eic_ctx_t saved_ctx;
  logic [IDX_W-1:0] active_irq;
  logic [NUM_EVT-1:0] evt_status;
  logic [NUM_EVT-1:0] evt_mask;
  logic [NUM_ERR-1:0] err_flags;

  // Command decode
  wire cmd_fire = cmd_valid_i & cmd_ready_o;
  wire is_enable = cmd_i.opcode == OP_ENABLE;
  wire is_disable = cmd_i.opcode == OP_DISABLE;
  wire is_clear = cmd_i.opcode == OP_CLEAR_ERR;
  wire is_vector = cmd_i.opcode == OP_VECTOR;
  wire is_return = cmd_i.opcode == OP_RETURN;
  wire is_ours = is_enable | is_disable | is_clear | is_vector | is_return;
  wire type_global = cmd_i.itype == TYPE_GLOBAL;
  wire type_in_range = cmd_i.itype < IRQ_COUNT;
  wire [IDX_W-1:0] type_idx = cmd_i.itype[IDX_W-1:0];
  wire do_enable = cmd_fire & is_enable;
  wire do_disable = cmd_fire & is_disable;
  wire do_clear = cmd_fire & is_clear;
  wire do_vector = cmd_fire & is_vector & type_in_range;
  // Return outside a handler has no saved context to reload
  wire do_return = cmd_fire & is_return & (mode == EIC_HANDLER);

  // Clear mask from the type field; unknown codes clear nothing
  logic [NUM_ERR-1:0] clr_sel;
  always_comb begin
    clr_sel = '0;
    if (cmd_i.itype == CLR_ALL) begin
      clr_sel = '1; // see [R2]
    end else if (cmd_i.itype <= CLR_LAST) begin
      clr_sel[cmd_i.itype[2:0] - 3'h1] = 1'b1; // see [R2]
    end
  end
  wire [NUM_ERR-1:0] err_clr = do_clear ? clr_sel : '0;

  // Lowest numbered enabled pending source wins
  wire [NUM_IRQ-1:0] irq_ready = irq_pending & irq_enable;
  logic [IDX_W-1:0] pick_idx;
  always_comb begin
    pick_idx = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_ready[i]) begin
        pick_idx = IDX_W'(i);
      end
    end
  end
  // A command in flight holds off entry so context is not torn
  wire take_irq = global_en & (mode == EIC_NORMAL) & boundary_i & ~cmd_valid_i & (|irq_ready);

  // Handler mode
  always_comb begin
    next_mode = mode;
    unique case (mode)
      EIC_NORMAL: begin
        if (take_irq) begin
          next_mode = EIC_HANDLER; // see [R11]
        end
      end
      EIC_HANDLER: begin
        if (do_return) begin
          next_mode = EIC_NORMAL; // see [R10]
        end
      end
    endcase
  end

  // Enables: 255 is the global switch, others per source
  logic [NUM_IRQ-1:0] next_enable;
  always_comb begin
    next_enable = irq_enable;
    if (do_enable & ~type_global & type_in_range) begin
      next_enable[type_idx] = 1'b1; // see [R3]
    end
    if (do_disable & ~type_global & type_in_range) begin
      next_enable[type_idx] = 1'b0; // see [R4]
    end
  end

  // Register bus
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [31:0] rd_word;
  logic rd_hit;
  wire [ADDR_W-1:0] vec_rd_off = s_araddr - ADDR_VEC_BASE;
  wire vec_rd_hit = (s_araddr >= ADDR_VEC_BASE) & (vec_rd_off[1:0] == 2'h0)
                    & ({2'h0, vec_rd_off[ADDR_W-1:2]} < IRQ_COUNT);
  wire [IDX_W-1:0] vec_rd_idx = IDX_W'(vec_rd_off[ADDR_W-1:2]);
  wire wr_hit = (wr_addr == ADDR_EVENT) | (wr_addr == ADDR_MASK);
  wire wr_event = wr_en & (wr_addr == ADDR_EVENT);
  wire wr_mask = wr_en & (wr_addr == ADDR_MASK);

  // Read selection; read-only words ignore writes
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case (s_araddr)
      ADDR_ERR: rd_word = 32'(err_flags);
      ADDR_ENABLE: rd_word = 32'(irq_enable);
      ADDR_EVENT: rd_word = 32'(evt_status);
      ADDR_MASK: rd_word = 32'(evt_mask);
      ADDR_STATE: begin
        rd_word[STATE_HANDLER] = mode == EIC_HANDLER;
        rd_word[STATE_GLOBAL] = global_en;
        rd_word[STATE_ACTIVE_LSB +: IDX_W] = active_irq;
      end
      default: begin
        rd_hit = vec_rd_hit;
        rd_word = vec_rd_hit ? vec_table[vec_rd_idx] : 32'h0000_0000;
      end
    endcase
  end

  eic_axil_slave u_bus (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid),
    .s_awready(s_awready),
    .s_wdata(s_wdata),
    .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid),
    .s_wready(s_wready),
    .s_bresp(s_bresp),
    .s_bvalid(s_bvalid),
    .s_bready(s_bready),
    .s_araddr(s_araddr),
    .s_arvalid(s_arvalid),
    .s_arready(s_arready),
    .s_rdata(s_rdata),
    .s_rresp(s_rresp),
    .s_rvalid(s_rvalid),
    .s_rready(s_rready),
    .rd_word_i(rd_word),
    .rd_hit_i(rd_hit),
    .wr_hit_i(wr_hit),
    .wr_en_o(wr_en),
    .wr_addr_o(wr_addr),
    .wr_data_o(wr_data)
  );

  // Events; a new event beats a same-cycle write-one clear
  logic [NUM_EVT-1:0] evt_set;
  assign evt_set[EVT_ENTER] = take_irq;
  assign evt_set[EVT_RETURN] = do_return;
  assign evt_set[EVT_ERROR] = |err_set_i;
  wire [NUM_EVT-1:0] evt_clr = wr_event ? wr_data[NUM_EVT-1:0] : '0;

  // Error flags: hardware set wins over a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      err_flags <= '0;
    end else begin
      err_flags <= (err_flags & ~err_clr) | err_set_i; // see [R1]
    end
  end

  // Interrupt control state
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      global_en <= 1'b0;
      irq_enable <= '0;
      irq_pending <= '0;
      mode <= EIC_NORMAL;
      active_irq <= '0;
    end else begin
      if ((do_enable | do_disable) & type_global) begin
        global_en <= do_enable; // see [R3] [R4]
      end
      irq_enable <= next_enable;
      irq_pending <= (irq_pending & ~(take_irq ? NUM_IRQ'(1) << pick_idx : '0))
                     | irq_req_i;
      mode <= next_mode;
      if (take_irq) begin
        active_irq <= pick_idx;
      end
    end
  end

  // Vector table, one word per source, last write stays
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_IRQ; i++) begin
        vec_table[i] <= 32'h0000_0000;
      end
    end else if (do_vector) begin
      vec_table[type_idx] <= cmd_i.value; // see [R5] [R6]
    end
  end

  // Context save on entry, reload on return
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      saved_ctx <= '0;
      jump_valid_o <= 1'b0;
      jump_pc_o <= 32'h0000_0000;
      restore_valid_o <= 1'b0;
      restore_o <= '0;
    end else begin
      jump_valid_o <= take_irq;
      restore_valid_o <= do_return;
      if (take_irq) begin
        saved_ctx <= ctx_i; // see [R11]
        jump_pc_o <= vec_table[pick_idx]; // see [R11]
      end
      if (do_return) begin
        restore_o <= saved_ctx; // see [R8]
      end
    end
  end

  // Direct-mode reply; value carries nothing
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      cmd_ready_o <= 1'b0;
      rsp_valid_o <= 1'b0;
      rsp_o <= '0;
    end else begin
      cmd_ready_o <= 1'b1;
      rsp_valid_o <= cmd_fire & is_ours & cmd_i.direct; // see [R12]
      if (cmd_fire & is_ours & cmd_i.direct) begin
        rsp_o.status <= STATUS_OK; // see [R12]
        rsp_o.opcode <= cmd_i.opcode;
        rsp_o.value <= 32'h0000_0000;
      end
    end
  end

  // Event status, mask and interrupt line
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      evt_status <= '0;
      evt_mask <= '0;
      irq_o <= 1'b0;
    end else begin
      evt_status <= (evt_status & ~evt_clr) | evt_set;
      if (wr_mask) begin
        evt_mask <= wr_data[NUM_EVT-1:0];
      end
      irq_o <= |(((evt_status & ~evt_clr) | evt_set) & evt_mask);
    end
  end

  assign err_flags_o = err_flags;

endmodule

//--- tb/eic_core_properties.sv
module eic_core_properties import eic_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic reset_i, // Sync reset
  input wire logic cmd_valid_i, // Command offered
  input wire eic_cmd_t cmd_i, // Command fields
  input wire logic cmd_ready_o, // Command accepted
  input wire logic rsp_valid_o, // Reply pulse
  input wire eic_reply_t rsp_o, // Reply fields
  input wire logic jump_valid_o, // Handler entry
  input wire logic restore_valid_o, // Handler return
  input wire logic [NUM_ERR-1:0] err_set_i, // Flag set pulses
  input wire logic [NUM_ERR-1:0] err_flags_o, // Flags
  input wire logic s_bvalid, // Write response valid
  input wire logic s_bready // Write response ready
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  logic take;
  logic five;
  logic hdl_now;
  logic in_hdl;
  logic [NUM_ERR-1:0] clr;
  // Decode of a taken command; flags targeted by a clear
  assign take = cmd_valid_i && cmd_ready_o;
  assign five = cmd_i.opcode inside {OP_ENABLE, OP_DISABLE, OP_CLEAR_ERR, OP_VECTOR, OP_RETURN};
  assign clr = (!take || cmd_i.opcode != OP_CLEAR_ERR) ? '0 :
    (cmd_i.itype == CLR_ALL) ? '1 :
    (cmd_i.itype <= CLR_LAST) ? NUM_ERR'(1) << (cmd_i.itype - 8'h01) : '0;
  // Handler mode as seen at the ports; entry pulse rises on the same edge as the mode
  assign hdl_now = (in_hdl && !restore_valid_o) || jump_valid_o;
  always_ff @(posedge clk_i) begin
    if (reset_i) in_hdl <= 1'b0;
    else if (jump_valid_o) in_hdl <= 1'b1;
    else if (restore_valid_o) in_hdl <= 1'b0;
  end
  sequence s_dir_take;
    take && cmd_i.direct && five;
  endsequence
  sequence s_ret_take;
    take && cmd_i.opcode == OP_RETURN;
  endsequence
  reply_status_a: assert property (s_dir_take |=> rsp_valid_o && rsp_o.status == STATUS_OK
    && rsp_o.opcode == $past(cmd_i.opcode)) else $error("reply missing or wrong");
  reply_cause_a: assert property (rsp_valid_o |-> $past(take && cmd_i.direct && five))
    else $error("reply without command");
  flag_clear_a: assert property (|clr |=> (err_flags_o & $past(clr) & ~$past(err_set_i)) == '0)
    else $error("flag not cleared");
  flag_keep_a: assert property (!(|err_set_i) |=>
    (err_flags_o & ~$past(clr)) == ($past(err_flags_o) & ~$past(clr))) else $error("flag changed");
  flag_set_a: assert property (|err_set_i |=> (err_flags_o & $past(err_set_i)) == $past(err_set_i))
    else $error("flag not set");
  ret_restore_a: assert property (s_ret_take and hdl_now |=> restore_valid_o)
    else $error("return did not restore");
  restore_cause_a: assert property (restore_valid_o |-> $past(take && cmd_i.opcode == OP_RETURN)
    && $past(hdl_now)) else $error("restore without return");
  no_nest_a: assert property (jump_valid_o |-> !$past(hdl_now) && $past(!cmd_valid_i))
    else $error("nested or early entry");
  bresp_hold_a: assert property (s_bvalid && !s_bready |=> s_bvalid) else $error("bvalid dropped");
endmodule

//--- tb/eic_host_model.sv
module eic_host_model import eic_pkg::*; (
  input wire logic clk_i, // Clock
  input wire logic cmd_ready_i, // Command accepted
  output logic cmd_valid_o, // Command offered
  output eic_cmd_t cmd_o // Command fields
);
  initial begin
    cmd_valid_o = 1'b0;
    cmd_o = '0;
  end
  // Offer one command and hold it until taken; valid stays up for back to back use
  task automatic send(input eic_cmd_t c);
    if (c.opcode == OP_VECTOR) c.direct = 1'b0;
    cmd_valid_o <= 1'b1;
    cmd_o <= c;
    do @(posedge clk_i); while (cmd_ready_i !== 1'b1);
  endtask
  // Release; fields scrambled so stale values are never mistaken for a command
  task automatic done();
    cmd_valid_o <= 1'b0;
    cmd_o <= ~cmd_o;
  endtask
endmodule

//--- tb/tb_error_flag_and_interrupt_cmds.sv
module tb_error_flag_and_interrupt_cmds import eic_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  localparam int NIRQ = 16;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic cmd_valid_i, cmd_ready_o, rsp_valid_o, jump_valid_o, restore_valid_o, irq_o, boundary_i;
  eic_cmd_t cmd_i;
  eic_reply_t rsp_o;
  eic_ctx_t ctx_i, restore_o, saved;
  logic [NIRQ-1:0] irq_req_i;
  logic [31:0] jump_pc_o, s_wdata, s_rdata;
  logic [NUM_ERR-1:0] err_set_i, err_flags_o;
  logic [ADDR_W-1:0] s_awaddr, s_araddr;
  logic [3:0] s_wstrb;
  logic [1:0] s_bresp, s_rresp;
  logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
  logic s_arvalid, s_arready, s_rvalid, s_rready;
  int failures = 0;
  int samples_checked = 0;
  int jumps = 0;
  logic [31:0] rnd = 32'hFA17;
  always #50 clk_i = ~clk_i;
  eic_core #(.NUM_IRQ(NIRQ)) u_eic_core (.clk_i(clk_i), .reset_i(reset_i),
    .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
    .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .irq_req_i(irq_req_i), .boundary_i(boundary_i),
    .ctx_i(ctx_i), .jump_valid_o(jump_valid_o), .jump_pc_o(jump_pc_o),
    .restore_valid_o(restore_valid_o), .restore_o(restore_o), .err_set_i(err_set_i),
    .err_flags_o(err_flags_o), .s_awaddr(s_awaddr), .s_awvalid(s_awvalid),
    .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
    .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
    .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .irq_o(irq_o));
  eic_host_model u_eic_host_model (.clk_i(clk_i), .cmd_ready_i(cmd_ready_o),
    .cmd_valid_o(cmd_valid_i), .cmd_o(cmd_i));
  // Handler entries seen so far
  always @(posedge clk_i) if (jump_valid_o === 1'b1) jumps <= jumps + 1;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Flags left after a clear of type t; out-of-range types clear nothing
  function automatic logic [4:0] after_clear(input logic [4:0] f, input int t);
    if (t == 0) return 5'h00;
    if (t > 5) return f;
    return f & ~(5'h01 << (t - 1));
  endfunction
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  // One command through the issuer, then the reply looked at in its single cycle
  task automatic cmd(input logic [7:0] op, input logic [7:0] t, input logic [31:0] v, input logic d);
    eic_cmd_t c;
    c = '{direct: d, opcode: op, itype: t, bank: rnd[7:0], value: v};
    rnd = lfsr(rnd);
    u_eic_host_model.send(c);
    u_eic_host_model.done();
    #1;
    chk("reply valid", 32'(d && op != OP_VECTOR), 32'(rsp_valid_o));
    if (d && op != OP_VECTOR) chk("reply", {16'h0, STATUS_OK, op}, 32'(rsp_o[47:32]));
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    s_awaddr <= a;
    s_wdata <= d;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_awready) s_awvalid <= 1'b0;
      if (s_wready) s_wvalid <= 1'b0;
    end while (s_bvalid !== 1'b1);
    chk("write resp", 32'(er), 32'(s_bresp));
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_arready) s_arvalid <= 1'b0;
    end while (s_rvalid !== 1'b1);
    chk("read data", ed, s_rdata);
    chk("read resp", 32'(er), 32'(s_rresp));
  endtask
  // Source n pulsed, then a fixed settle time before the entry count is judged
  task automatic pulse_irq(input int n);
    @(posedge clk_i);
    irq_req_i <= NIRQ'(1) << n;
    @(posedge clk_i);
    irq_req_i <= '0;
    repeat (8) @(posedge clk_i);
  endtask
  task automatic end_of_test();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk_i);
    failures++;
    end_of_test();
  end
  initial begin
    logic [4:0] ef;
    logic [31:0] v;
    int n;
    ef = 5'h00;
    {irq_req_i, boundary_i, ctx_i, err_set_i, s_awaddr, s_wdata} = '0;
    {s_awvalid, s_wvalid, s_bready, s_araddr, s_arvalid, s_rready} = '0;
    s_wstrb = 4'hF;
    repeat (3) @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    rd(ADDR_STATE, 32'h0, RESP_OKAY);
    rd(ADDR_MASK, 32'h0, RESP_OKAY);
    rd(8'h80, 32'h0, RESP_DECERR);
    wr(ADDR_ERR, 32'hFF, RESP_DECERR);
    $display("test registers done");
    // Random flags set, then every clear type including one past the last
    for (int t = 0; t <= 6; t++) begin
      @(posedge clk_i);
      err_set_i <= rnd[4:0];
      ef = ef | rnd[4:0];
      rnd = lfsr(rnd);
      @(posedge clk_i);
      err_set_i <= '0;
      cmd(OP_CLEAR_ERR, 8'(t), rnd, rnd[0]);
      ef = after_clear(ef, t);
      chk("error flags", 32'(ef), 32'(err_flags_o));
    end
    rd(ADDR_ERR, 32'(ef), RESP_OKAY);
    $display("test error flags done");
    n = int'(rnd[3:0]);
    v = lfsr(rnd);
    cmd(OP_VECTOR, 8'(n), rnd, 1'b1);
    cmd(OP_VECTOR, 8'(n), v, 1'b0);
    rd(ADDR_VEC_BASE + 8'(4 * n), v, RESP_OKAY);
    cmd(OP_ENABLE, 8'(n), 32'h0, 1'b1);
    cmd(OP_ENABLE, TYPE_GLOBAL, 32'h0, 1'b1);
    rd(ADDR_ENABLE, 32'h1 << n, RESP_OKAY);
    wr(ADDR_EVENT, 32'h7, RESP_OKAY);
    // Unstrobed low byte lands as zero
    s_wstrb <= 4'hE;
    wr(ADDR_MASK, 32'h7, RESP_OKAY);
    s_wstrb <= 4'hF;
    rd(ADDR_MASK, 32'h0, RESP_OKAY);
    wr(ADDR_MASK, 32'h1, RESP_OKAY);
    rd(ADDR_MASK, 32'h1, RESP_OKAY);
    saved = {lfsr(v), v, rnd[7:0], rnd};
    ctx_i <= saved;
    boundary_i <= 1'b1;
    pulse_irq(n);
    chk("entries", 32'h1, jumps);
    chk("entry pc", v, jump_pc_o);
    ctx_i <= ~saved;
    rd(ADDR_EVENT, 32'h1, RESP_OKAY);
    chk("irq out", 32'h1, 32'(irq_o));
    wr(ADDR_EVENT, 32'h1, RESP_OKAY);
    @(posedge clk_i);
    #1;
    chk("irq out", 32'h0, 32'(irq_o));
    // Handler ends with its return; a second return finds no handler
    cmd(OP_RETURN, 8'hFF, 32'h0, 1'b1);
    chk("restore", 32'h1, 32'(restore_valid_o));
    chk("restore ctx", 32'h1, 32'(restore_o === saved));
    cmd(OP_RETURN, 8'hFF, 32'h0, 1'b1);
    chk("restore", 32'h0, 32'(restore_valid_o));
    $display("test entry and return done");
    cmd(OP_DISABLE, 8'(n), 32'h0, 1'b1);
    rd(ADDR_ENABLE, 32'h0, RESP_OKAY);
    pulse_irq(n);
    cmd(OP_DISABLE, TYPE_GLOBAL, 32'h0, 1'b0);
    cmd(OP_ENABLE, 8'(n), 32'h0, 1'b0);
    pulse_irq(n);
    chk("entries", 32'h1, jumps);
    cmd(OP_ENABLE, TYPE_GLOBAL, 32'h0, 1'b0);
    pulse_irq(n);
    chk("entries", 32'h2, jumps);
    cmd(OP_RETURN, 8'hFF, 32'h0, 1'b0);
    chk("restore", 32'h1, 32'(restore_valid_o));
    $display("test disable done");
    end_of_test();
  end
endmodule
bind eic_core eic_core_properties u_eic_core_properties (.clk_i(clk_i), .reset_i(reset_i),
  .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i), .cmd_ready_o(cmd_ready_o),
  .rsp_valid_o(rsp_valid_o), .rsp_o(rsp_o), .jump_valid_o(jump_valid_o),
  .restore_valid_o(restore_valid_o), .err_set_i(err_set_i), .err_flags_o(err_flags_o),
  .s_bvalid(s_bvalid), .s_bready(s_bready));
